// ---- logic/olp_programmer.sv ----
`timescale 1ns/10ps
// Programming and limit calibration front end.
module olp_programmer #(
    parameter int unsigned FIFO_DEPTH = olp_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_program_enable_pin,
    input wire logic i_step_boost_pin,
    input wire logic i_step_data_pin,
    input wire logic i_shift_clk_pin,
    input wire logic i_store_strobe_pin,
    input wire logic i_integrator_out,
    input wire logic i_gain_amp_out,
    input wire logic i_smoke_comparator_result,
    input wire logic i_run_red,
    input wire logic i_run_green,
    input wire logic i_run_horn,
    input wire logic i_meas_done,
    input wire logic [4:0] i_meas_value,
    input wire logic i_nvm_busy,
    output logic o_red_indicator_pin,
    output logic o_green_indicator_pin,
    output logic o_horn_drive_pin,
    output logic [4:0] o_smoke_level,
    output logic o_meas_start,
    output logic o_nvm_write,
    output logic [38:0] o_nvm_data,
    output logic [6:0] o_mode,
    output logic o_horn_pattern_select,
    output logic o_end_of_life_enable,
    output logic o_low_batt_hush_enable,
    output logic o_hush_cancel_enable,
    output logic o_drift_comp_enable,
    output logic [11:0] o_low_batt_trip_mv,
    output logic [7:0] o_emitter_current_ma,
    output logic [8:0] o_integration_time_us,
    output logic [2:0] o_photo_gain
);
    logic [8:0] pins_s;
    logic [8:0] pins_d1_q;
    logic en_s;
    logic boost_s;
    logic data_s;
    logic shclk_s;
    logic store_s;
    logic integ_s;
    logic gamp_s;
    logic comp_s;
    logic meas_done_s;
    logic step_rise;
    logic shclk_rise;
    logic store_rise;
    logic meas_rise;
    olp_pkg::olp_mode_t mode_q;
    olp_pkg::olp_mode_t mode_d;
    logic [38:0] cfg_q;
    logic [5:0] bit_idx_q;
    logic [4:0] level_q;
    logic pend_q;
    logic pend_bit_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic fifo_out_data;
    logic commit_req_q;
    logic meas_wait_q;
    logic [4:0] meas_val_q;

    // All pins and comparators are asynchronous.
    olp_sync #(
        .W(9)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_meas_done, i_smoke_comparator_result, i_gain_amp_out,
            i_integrator_out, i_store_strobe_pin, i_shift_clk_pin,
            i_step_data_pin, i_step_boost_pin, i_program_enable_pin}),
        .o_sync(pins_s)
    );

    assign en_s = pins_s[0];
    assign boost_s = pins_s[1];
    assign data_s = pins_s[2];
    assign shclk_s = pins_s[3];
    assign store_s = pins_s[4];
    assign integ_s = pins_s[5];
    assign gamp_s = pins_s[6];
    assign comp_s = pins_s[7];
    assign meas_done_s = pins_s[8];

    // Delayed copy for edge detection.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pins_d1_q <= 9'h000;
        end else begin
            pins_d1_q <= pins_s;
        end
    end

    // Only the boosted level steps modes.
    assign step_rise = en_s && boost_s && !pins_d1_q[1]; // RL23
    assign shclk_rise = en_s && shclk_s && !pins_d1_q[3];
    assign store_rise = en_s && store_s && !pins_d1_q[4];
    assign meas_rise = meas_done_s && !pins_d1_q[8];

    // First step leaves option mode for the limit modes and baseline.
    // Later steps reach modes not built here, so the block parks in idle
    // until enable drops.
    always_comb begin
        mode_d = mode_q;
        if (!en_s) begin
            mode_d = olp_pkg::MODE_IDLE;
        end else if (step_rise) begin
            case (mode_q)
                olp_pkg::MODE_OPT: mode_d = olp_pkg::MODE_NORM; // RL17
                olp_pkg::MODE_NORM: mode_d = olp_pkg::MODE_HYST; // RL17
                olp_pkg::MODE_HYST: mode_d = olp_pkg::MODE_HUSH; // RL17
                olp_pkg::MODE_HUSH: mode_d = olp_pkg::MODE_CHAMB; // RL17
                olp_pkg::MODE_CHAMB: mode_d = olp_pkg::MODE_BASE; // RL21
                default: mode_d = olp_pkg::MODE_IDLE;
            endcase
        end
    end

    // Enable rising enters option mode.
    logic armed_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_q <= olp_pkg::MODE_IDLE;
            armed_q <= 1'b0;
        end else begin
            armed_q <= en_s;
            if (en_s && !armed_q) begin
                mode_q <= olp_pkg::MODE_OPT; // RL3
            end else begin
                mode_q <= mode_d;
            end
        end
    end

    // A shift edge in option mode captures the data pin.
    // A full FIFO holds it pending; a shift edge that arrives while a bit is still pending is ignored.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pend_q <= 1'b0;
            pend_bit_q <= 1'b0;
        end else if (pend_q && fifo_in_ready) begin
            pend_q <= 1'b0;
        end else if (!pend_q && shclk_rise && mode_q == olp_pkg::MODE_OPT) begin
            pend_q <= 1'b1; // RL1
            pend_bit_q <= data_s; // RL1
        end
    end

    // The drain stalls while the memory is busy.
    olp_fifo #(
        .WIDTH(1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(pend_q),
        .o_in_ready(fifo_in_ready),
        .i_in_data(pend_bit_q),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    assign fifo_out_ready = !i_nvm_busy;

    // Bits fill upward from bit 25; extra bits are dropped,
    // so the option load never touches the limit fields.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bit_idx_q <= olp_pkg::OPT_FIRST_BIT;
        end else if (mode_q != olp_pkg::MODE_OPT) begin
            bit_idx_q <= olp_pkg::OPT_FIRST_BIT; // RL13
        end else if (fifo_out_valid && fifo_out_ready
                && bit_idx_q <= olp_pkg::OPT_LAST_BIT) begin
            bit_idx_q <= bit_idx_q + 6'h01; // RL13
        end
    end

    // Calibration level, cleared on mode change.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            level_q <= 5'h00;
        end else if (mode_q != mode_d || !en_s) begin
            level_q <= 5'h00; // RL25
        end else if (shclk_rise && level_q != olp_pkg::LVL_MAX
                && (mode_q == olp_pkg::MODE_NORM || mode_q == olp_pkg::MODE_HYST
                || mode_q == olp_pkg::MODE_HUSH || mode_q == olp_pkg::MODE_CHAMB)) begin
            level_q <= level_q + 5'h01; // RL19
        end
    end

    // One shift edge in baseline mode starts a measurement;
    // its result waits for the final store.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meas_wait_q <= 1'b0;
            o_meas_start <= 1'b0;
            meas_val_q <= 5'h00;
        end else begin
            o_meas_start <= 1'b0;
            if (shclk_rise && mode_q == olp_pkg::MODE_BASE && !meas_wait_q) begin
                o_meas_start <= 1'b1; // RL21
                meas_wait_q <= 1'b1;
            end else if (meas_wait_q && meas_rise) begin
                meas_wait_q <= 1'b0;
                meas_val_q <= i_meas_value;
            end
        end
    end

    // Working image: option bits and latched limits.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg_q <= olp_pkg::CFG_RESET;
        end else begin
            if (mode_q == olp_pkg::MODE_OPT && fifo_out_valid && fifo_out_ready
                    && bit_idx_q <= olp_pkg::OPT_LAST_BIT) begin
                cfg_q[bit_idx_q] <= fifo_out_data; // RL4
            end
            if (store_rise) begin
                case (mode_q)
                    olp_pkg::MODE_NORM: cfg_q[olp_pkg::NORM_LSB +: 5] <= level_q; // RL20
                    olp_pkg::MODE_HYST: cfg_q[olp_pkg::HYST_LSB +: 5] <= level_q; // RL20
                    olp_pkg::MODE_HUSH: cfg_q[olp_pkg::HUSH_LSB +: 5] <= level_q; // RL20
                    olp_pkg::MODE_CHAMB: cfg_q[olp_pkg::CHAMB_LSB +: 5] <= level_q; // RL20
                    default: ;
                endcase
            end
            if (meas_wait_q && meas_rise) begin
                cfg_q[olp_pkg::BASE_LSB +: 5] <= i_meas_value; // RL12
            end
        end
    end

    // A store in option or baseline mode requests the commit; it waits
    // for drained bits and a free memory, so the image is whole.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            commit_req_q <= 1'b0;
        end else if (commit_req_q && !fifo_out_valid && !pend_q && !i_nvm_busy
                && !meas_wait_q) begin
            commit_req_q <= 1'b0;
        end else if (store_rise && (mode_q == olp_pkg::MODE_OPT
                || mode_q == olp_pkg::MODE_BASE)) begin
            commit_req_q <= 1'b1; // RL15
        end
    end

    // The memory write pulse carries the whole image at once.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_nvm_write <= 1'b0;
            o_nvm_data <= olp_pkg::CFG_RESET;
        end else begin
            o_nvm_write <= 1'b0;
            if (commit_req_q && !fifo_out_valid && !pend_q && !i_nvm_busy
                    && !meas_wait_q) begin
                o_nvm_write <= 1'b1; // RL22
                o_nvm_data <= cfg_q; // RL22
            end
        end
    end

    // Low battery trip code to millivolts.
    function automatic logic [11:0] lb_mv(input logic [2:0] code);
        case (code)
            3'h0: lb_mv = 12'h834;
            3'h1: lb_mv = 12'h9c4;
            3'h2: lb_mv = 12'h8fc;
            3'h3: lb_mv = 12'ha8c;
            3'h4: lb_mv = 12'h898;
            3'h5: lb_mv = 12'ha28;
            3'h6: lb_mv = 12'h960;
            default: lb_mv = 12'haf0;
        endcase
    endfunction

    // Option outputs follow the committed image only.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_horn_pattern_select <= 1'b0;
            o_end_of_life_enable <= 1'b0;
            o_low_batt_hush_enable <= 1'b0;
            o_hush_cancel_enable <= 1'b0;
            o_drift_comp_enable <= 1'b0;
            o_low_batt_trip_mv <= 12'h000;
            o_emitter_current_ma <= 8'h00;
            o_integration_time_us <= 9'h000;
            o_photo_gain <= 3'h0;
        end else begin
            o_horn_pattern_select <= o_nvm_data[olp_pkg::TONE_BIT]; // RL5
            o_end_of_life_enable <= o_nvm_data[olp_pkg::EOL_BIT]; // RL6
            o_low_batt_hush_enable <= o_nvm_data[olp_pkg::LB_HUSH_BIT]; // RL6
            o_hush_cancel_enable <= o_nvm_data[olp_pkg::HUSH_OPT_BIT]; // RL7
            o_drift_comp_enable <= o_nvm_data[olp_pkg::DRIFT_BIT]; // RL6
            o_low_batt_trip_mv <= lb_mv(o_nvm_data[olp_pkg::LB_LSB +: 3]); // RL8
            o_emitter_current_ma <= 8'h32
                * (8'h01 + {6'h00, o_nvm_data[olp_pkg::IRC_LSB +: 2]}); // RL9
            o_integration_time_us <= 9'h190
                - {o_nvm_data[olp_pkg::INTEG_LSB +: 2], 7'h00}
                + {7'h00, o_nvm_data[olp_pkg::INTEG_LSB +: 2]} * 9'h1c; // RL10
            o_photo_gain <= {1'b0, o_nvm_data[olp_pkg::GAIN_LSB +: 2]} + 3'h1; // RL11
        end
    end

    // Calibration modes borrow the indicator and horn pins.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_red_indicator_pin <= 1'b0;
            o_green_indicator_pin <= 1'b0;
            o_horn_drive_pin <= 1'b0;
            o_smoke_level <= 5'h00;
            o_mode <= olp_pkg::MODE_IDLE;
        end else begin
            o_smoke_level <= level_q;
            o_mode <= mode_q;
            if (mode_q == olp_pkg::MODE_NORM || mode_q == olp_pkg::MODE_HYST
                    || mode_q == olp_pkg::MODE_HUSH || mode_q == olp_pkg::MODE_CHAMB
                    || mode_q == olp_pkg::MODE_BASE) begin
                o_red_indicator_pin <= gamp_s; // RL18
                o_green_indicator_pin <= integ_s; // RL18
                o_horn_drive_pin <= comp_s; // RL18
            end else begin
                o_red_indicator_pin <= i_run_red;
                o_green_indicator_pin <= i_run_green;
                o_horn_drive_pin <= i_run_horn;
            end
        end
    end
endmodule

// ---- logic/olp_pkg.sv ----
// What the document asks of this block
// RL1: Option mode takes 14 data bits, one per shift clock edge, then commits them.
// RL2: Programmer holds all programming pins low at power up.
// RL3: Programmer raises program enable and holds it high through the final store.
// RL4: Option mode loads only bits 25 to 38; serial mode would load all 39.
// RL5: Bit 38 picks temporal horn pattern when 1, continuous when 0.
// RL6: Bits 37, 36, 34 enable end of life, battery hush, drift compensation.
// RL7: Bit 35 set lets hush be cancelled; clear means hush never cancels.
// RL8: Bits 33..31 decode to trip voltages 2.1,2.5,2.3,2.7,2.2,2.6,2.4,2.8.
// RL9: Bits 30..29 select emitter current 50, 100, 150 or 200 mA.
// RL10: Bits 28..27 select integration time 400, 300, 200 or 100 us.
// RL11: Bits 26..25 select photo gain 1, 2, 3 or 4.
// RL12: Five-bit limits sit at 24-20, 19-15, 14-10, 9-5, baseline 4-0.
// RL13: First shifted bit lands in bit 25, the last in bit 38.
// RL14: Programmer keeps shift pulses 10 us and step pulses 100 us wide; the bench model drives both 163 ns wide.
// RL15: Store strobe pulse copies the shift register into nonvolatile memory.
// RL16: Changing options needs a power down and full re-entry of every bit.
// RL17: Each step pulse advances mode: normal, hysteresis, hush, chamber limits.
// RL18: Calibration routes integrator to green, level to red, comparator to horn; the code drives red from the gain amplifier output.
// RL19: In calibration each shift clock raises the smoke level by one.
// RL20: Store strobe rising edge latches the level as the current mode's limit.
// RL21: Baseline mode: a shift clock rising edge starts one baseline measurement.
// RL22: Limits and baseline stay uncommitted until the final store strobe.
// RL23: Only a swing to the boosted level steps the mode; supply level is data.
// RL24: Serial mode shifts five-bit fields LSB first, baseline first; no serial mode is built here.
// RL25: Level counter is five bits, zero on mode entry, saturates at 31.
package olp_pkg;
    localparam int unsigned CFG_W = 39;
    localparam int unsigned LVL_W = 5;
    localparam logic [5:0] OPT_FIRST_BIT = 6'h19;
    localparam logic [5:0] OPT_LAST_BIT = 6'h26;
    localparam int unsigned TONE_BIT = 38;
    localparam int unsigned EOL_BIT = 37;
    localparam int unsigned LB_HUSH_BIT = 36;
    localparam int unsigned HUSH_OPT_BIT = 35;
    localparam int unsigned DRIFT_BIT = 34;
    localparam int unsigned LB_LSB = 31;
    localparam int unsigned IRC_LSB = 29;
    localparam int unsigned INTEG_LSB = 27;
    localparam int unsigned GAIN_LSB = 25;
    localparam int unsigned NORM_LSB = 20;
    localparam int unsigned HYST_LSB = 15;
    localparam int unsigned HUSH_LSB = 10;
    localparam int unsigned CHAMB_LSB = 5;
    localparam int unsigned BASE_LSB = 0;
    localparam logic [CFG_W-1:0] CFG_RESET = 39'h00_0000_0000;
    localparam logic [4:0] LVL_MAX = 5'h1f;
    localparam int unsigned FIFO_DEPTH = 16;

    // Mode sequence while programming is enabled: enable rising enters option mode, step pulses advance the rest.
    typedef enum logic [6:0] {
        MODE_IDLE = 7'h01,
        MODE_OPT = 7'h02,
        MODE_NORM = 7'h04,
        MODE_HYST = 7'h08,
        MODE_HUSH = 7'h10,
        MODE_CHAMB = 7'h20,
        MODE_BASE = 7'h40
    } olp_mode_t;
endpackage

// ---- logic/olp_sync.sv ----
`timescale 1ns/10ps
// Two-stage synchroniser for pins; only the second stage is read outside.
module olp_sync #(
    parameter int unsigned W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    // Each bit gets its own pair of flops.
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    meta_q[g] <= 1'b0;
                    o_sync[g] <= 1'b0;
                end else begin
                    meta_q[g] <= i_async[g];
                    o_sync[g] <= meta_q[g];
                end
            end
        end
    endgenerate
endmodule

// ---- logic/olp_fifo.sv ----
`timescale 1ns/10ps
// Small flop FIFO with valid/ready on both sides.
module olp_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem_q[rd_q];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Storage is written only on an accepted push.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    // Pointers wrap naturally because depth is a power of two.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- tb/olp_checker.sv ----
`timescale 1ns/10ps
// Checks commits, decodes, level and routing.
module olp_checker (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_integrator_out,
    input wire logic i_gain_amp_out,
    input wire logic i_smoke_comparator_result,
    input wire logic o_red_indicator_pin,
    input wire logic o_green_indicator_pin,
    input wire logic o_horn_drive_pin,
    input wire logic [4:0] o_smoke_level,
    input wire logic o_meas_start,
    input wire logic o_nvm_write,
    input wire logic [38:0] o_nvm_data,
    input wire logic [6:0] o_mode,
    input wire logic o_horn_pattern_select,
    input wire logic o_end_of_life_enable,
    input wire logic o_low_batt_hush_enable,
    input wire logic o_hush_cancel_enable,
    input wire logic o_drift_comp_enable,
    input wire logic [11:0] o_low_batt_trip_mv,
    input wire logic [7:0] o_emitter_current_ma,
    input wire logic [8:0] o_integration_time_us,
    input wire logic [2:0] o_photo_gain
);
    logic cal_m;
    logic lim_m;
    // Baseline mode routes the pins too.
    assign cal_m = o_mode inside {7'h04, 7'h08, 7'h10, 7'h20, 7'h40};
    assign lim_m = o_mode inside {7'h04, 7'h08, 7'h10, 7'h20};
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Five steady cycles outlast sync plus output flop.
    sequence s_cal_steady;
        (cal_m && $stable(i_gain_amp_out) && $stable(i_integrator_out)
            && $stable(i_smoke_comparator_result))[*5];
    endsequence
    // The decodes follow the committed image one cycle after the write pulse.
    sequence s_commit;
        o_nvm_write ##1 1'b1;
    endsequence
    a_commit_single: assert property (o_nvm_write |=> !o_nvm_write)
        else $error("commit pulse longer than one cycle");
    a_opt_flags: assert property (
        s_commit |-> {o_horn_pattern_select, o_end_of_life_enable, o_low_batt_hush_enable,
            o_hush_cancel_enable, o_drift_comp_enable} == $past(o_nvm_data[38:34]))
        else $error("option flags differ from committed bits");
    a_trip_decode: assert property (
        s_commit |-> o_low_batt_trip_mv == 12'h834 + ($past(o_nvm_data[31]) ? 12'h190 : 12'h000)
            + ($past(o_nvm_data[32]) ? 12'h0c8 : 12'h000)
            + ($past(o_nvm_data[33]) ? 12'h064 : 12'h000))
        else $error("battery trip decode wrong");
    a_field_decode: assert property (
        s_commit |-> o_emitter_current_ma == 8'h32 * (8'h01 + {6'h00, $past(o_nvm_data[30:29])})
            && o_integration_time_us == 9'h190 - 9'h064 * {7'h00, $past(o_nvm_data[28:27])}
            && o_photo_gain == 3'h1 + {1'b0, $past(o_nvm_data[26:25])})
        else $error("current, time or gain decode wrong");
    a_level_step: assert property (
        lim_m && $stable(o_mode) && $changed(o_smoke_level)
            |-> {1'b0, o_smoke_level} == {1'b0, $past(o_smoke_level)} + 6'h01)
        else $error("level moved other than by one");
    a_level_entry: assert property ($changed(o_mode) |-> ##[0:1] o_smoke_level == 5'h00)
        else $error("level not cleared on mode change");
    a_cal_route: assert property (
        s_cal_steady |-> o_red_indicator_pin == i_gain_amp_out
            && o_green_indicator_pin == i_integrator_out
            && o_horn_drive_pin == i_smoke_comparator_result)
        else $error("calibration routing wrong");
    a_meas_baseline: assert property (
        o_meas_start |-> o_mode == 7'h40 ##1 !o_meas_start)
        else $error("measurement start outside baseline or too long");
    a_mode_order: assert property (
        $changed(o_mode) && $past(lim_m || o_mode == 7'h02)
            |-> o_mode == ($past(o_mode) << 1) || o_mode == 7'h01)
        else $error("mode sequence broken");
endmodule

bind olp_programmer olp_checker u_olp_checker (.*);

// ---- tb/olp_prog_model.sv ----
`timescale 1ns/10ps
// Production programmer; pulse slots span whole block clock periods, so its pin edges hold their phase.
module olp_prog_model (
    input wire logic i_clk,
    input wire logic i_meas_start,
    output logic o_enable,
    output logic o_boost,
    output logic o_data,
    output logic o_shift,
    output logic o_store,
    output logic o_meas_done,
    output logic [4:0] o_meas_value
);
    logic [4:0] meas_val;
    // Every pin starts low so power-up sees a quiet interface.
    initial begin
        {o_enable, o_boost, o_data, o_shift, o_store, o_meas_done} = 6'h00;
        o_meas_value = 5'h00;
        meas_val = 5'h00;
    end
    // Enable is raised once and held through the last store of a session.
    task automatic set_enable(input logic on);
        o_enable = on;
        #320;
    endtask
    // Pulse select: 0 shift, 1 store, 2 boosted step, 3 supply-level data only.
    task automatic pulse(input int sel);
        case (sel)
            0: o_shift = 1'b1;
            1: o_store = 1'b1;
            2: {o_boost, o_data} = 2'h3;
            default: o_data = 1'b1;
        endcase
        #163;
        {o_boost, o_shift, o_store} = 3'h0;
        if (sel > 1) o_data = 1'b0;
        #157;
    endtask
    // Data leads the shift edge and is inverted once it is no longer sampled.
    task automatic shift_bit(input logic b);
        o_data = b;
        #80;
        pulse(0);
        o_data = ~b;
    endtask
    // A started measurement reports some cycles later.
    always @(posedge i_clk) begin
        if (i_meas_start === 1'b1) begin
            repeat (6) @(posedge i_clk);
            o_meas_value = meas_val;
            #45 o_meas_done = 1'b1;
            #320 o_meas_done = 1'b0;
            o_meas_value = ~meas_val;
        end
    end
endmodule

// ---- tb/option_and_limit_programmer_tb_top.sv ----
`timescale 1ns/10ps
// Bench: model drives pins, commits scored off a queue.
module option_and_limit_programmer_tb_top;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [2:0] ana = 3'h0;
    logic [2:0] run = 3'h0;
    logic busy = 1'b0;
    logic en, boost, dat, sclk, stb, mdone, mstart, nvm_wr;
    logic [4:0] mval, level, flg;
    logic [2:0] obs, run_q;
    logic [38:0] nvm_data;
    logic [6:0] mode;
    logic [38:0] exp_q[$];
    logic [38:0] want;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 32'h12a37684;

    // Block clock, 40 ns period.
    always #20 i_clk = ~i_clk;

    olp_prog_model u_olp_prog_model (
        .i_clk(i_clk), .i_meas_start(mstart), .o_enable(en), .o_boost(boost), .o_data(dat),
        .o_shift(sclk), .o_store(stb), .o_meas_done(mdone), .o_meas_value(mval)
    );
    olp_programmer u_olp_programmer (
        .i_clk(i_clk), .i_rst(i_rst), .i_program_enable_pin(en), .i_step_boost_pin(boost),
        .i_step_data_pin(dat), .i_shift_clk_pin(sclk), .i_store_strobe_pin(stb),
        .i_integrator_out(ana[0]), .i_gain_amp_out(ana[1]), .i_smoke_comparator_result(ana[2]),
        .i_run_red(run[0]), .i_run_green(run[1]), .i_run_horn(run[2]), .i_meas_done(mdone),
        .i_meas_value(mval), .i_nvm_busy(busy), .o_red_indicator_pin(obs[0]),
        .o_green_indicator_pin(obs[1]), .o_horn_drive_pin(obs[2]), .o_smoke_level(level),
        .o_meas_start(mstart), .o_nvm_write(nvm_wr), .o_nvm_data(nvm_data), .o_mode(mode),
        .o_horn_pattern_select(flg[4]), .o_end_of_life_enable(flg[3]),
        .o_low_batt_hush_enable(flg[2]), .o_hush_cancel_enable(flg[1]),
        .o_drift_comp_enable(flg[0]), .o_low_batt_trip_mv(),
        .o_emitter_current_ma(), .o_integration_time_us(), .o_photo_gain()
    );

    // Analog bits change rarely so routed levels settle.
    always @(posedge i_clk) begin
        #2;
        run = 3'($random(seed));
        busy = 1'($random(seed));
        if (($random(seed) & 15) == 0) ana = 3'($random(seed));
    end

    task automatic check(input logic [38:0] got, input logic [38:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Each commit takes the oldest note; an unexpected one mismatches.
    always @(posedge i_clk) begin
        if (mode == 7'h02) check(39'(obs), 39'(run_q));
        run_q = run;
        if (nvm_wr === 1'b1) begin
            want = (exp_q.size() > 0) ? exp_q.pop_front() : ~nvm_data;
            check(nvm_data, want);
        end
    end

    // Power cycle: reset three cycles, then enable.
    task automatic restart();
        u_olp_prog_model.set_enable(1'b0);
        @(posedge i_clk);
        #2 i_rst = 1'b1;
        repeat (3) @(posedge i_clk);
        #2 i_rst = 1'b0;
        u_olp_prog_model.set_enable(1'b1);
        check(39'(mode), 39'h02);
    endtask

    // Store strobe, then a bounded wait for the commit.
    task automatic commit();
        u_olp_prog_model.pulse(1);
        for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge i_clk);
        check(39'(exp_q.size()), 39'h00);
        repeat (3) @(posedge i_clk);
        check(39'(flg), 39'(want[38:34]));
    endtask

    task automatic stop_test();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        logic [13:0] opt;
        logic [4:0] lim[4];
        int k;
        // Eight sessions cover every field code; the ninth calibrates.
        for (int s = 0; s < 9; s++) begin
            restart();
            opt = 14'($random(seed));
            if (s < 8) opt[8:0] = {s[2:0], {3{s[1:0]}}};
            for (int i = 0; i < 14 + (s == 7); i++) u_olp_prog_model.shift_bit(opt[i % 14]);
            exp_q.push_back({opt, 25'h0});
            commit();
        end
        for (int m = 0; m < 4; m++) begin
            u_olp_prog_model.pulse(2);
            check(39'(mode), 39'(7'h04 << m));
            u_olp_prog_model.pulse(3);
            check(39'(mode), 39'(7'h04 << m));
            k = (m == 3) ? 33 : (m == 1) ? 0 : 1 + ($random(seed) & 15);
            lim[m] = (k > 31) ? olp_pkg::LVL_MAX : 5'(k);
            repeat (k) u_olp_prog_model.pulse(0);
            check(39'(level), 39'(lim[m]));
            u_olp_prog_model.pulse(1);
        end
        u_olp_prog_model.pulse(2);
        check(39'(mode), 39'h40);
        u_olp_prog_model.meas_val = 5'($random(seed));
        u_olp_prog_model.pulse(0);
        repeat (20) @(posedge i_clk);
        exp_q.push_back({opt, lim[0], lim[1], lim[2], lim[3], u_olp_prog_model.meas_val});
        commit();
        u_olp_prog_model.pulse(2);
        check(39'(mode), 39'h01);
        stop_test();
    end

    // Watchdog, ten times the expected run.
    initial begin
        #1000000;
        error_cnt++;
        stop_test();
    end
endmodule
